// *** gpiop_edge.sv ***
`timescale 1ns/10ps
module gpiop_edge
  import gpiop_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // pins and control
  input  wire logic [WIDTH-1:0] pin_async,
  input  wire logic [WIDTH-1:0] sel,
  input  wire logic [WIDTH-1:0] pol,
  // results
  output logic      [WIDTH-1:0] level_sync,
  output logic      [WIDTH-1:0] asserted,
  output logic      [WIDTH-1:0] edge_hit
);

  // ---------------------------------------------------------------------
  // synchroniser and edge history
  // ---------------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] armed_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_sync = sync_q;
  // polarity 1 means rising/high, 0 falling/low
  assign asserted   = sel & ~(sync_q ^ pol);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= '0;
    end else begin
      armed_q <= sel & (armed_q | (prev_q ^ pol));
    end
  end

  assign edge_hit = sel & armed_q & (prev_q ^ pol) & ~(sync_q ^ pol);

endmodule

// *** gpiop_pins_model.sv ***
`timescale 1ns/10ps
module gpiop_pins_model
  import gpiop_pkg::*;
(
  // clock
  input  wire logic          clk,
  // device side
  input  wire logic [7:0]    pin_out,
  input  wire logic [7:0]    pin_oe,
  input  wire gpiop_pad_type pad_ctl,
  // board side
  input  wire logic [7:0]    ext_val,
  input  wire logic [7:0]    ext_drv,
  output logic      [7:0]    pin_in
);
  // ---------------------------------------------------------------
  // pin level resolution
  // ---------------------------------------------------------------
  logic [7:0] float_q = 8'h5a;

  // undriven pins wander every cycle
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_drv[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pad_ctl.pull_en[i]) begin
        pin_in[i] = ~pad_ctl.pull_down[i];
      end else begin
        pin_in[i] = float_q[i];
      end
    end
  end
endmodule

// *** gpiop_pkg.sv ***
package gpiop_pkg;

  // ---------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------
  localparam logic [3:0] GPIOP_OFF_DATA     = 4'h0;
  localparam logic [3:0] GPIOP_OFF_DIR      = 4'h1;
  localparam logic [3:0] GPIOP_OFF_PULL     = 4'h2;
  localparam logic [3:0] GPIOP_OFF_SLEW     = 4'h3;
  localparam logic [3:0] GPIOP_OFF_DRIVE    = 4'h4;
  localparam logic [3:0] GPIOP_OFF_IRQ_SC   = 4'h5;
  localparam logic [3:0] GPIOP_OFF_IRQ_SEL  = 4'h6;
  localparam logic [3:0] GPIOP_OFF_IRQ_POL  = 4'h7;
  localparam logic [3:0] GPIOP_OFF_PWR      = 4'h8;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int GPIOP_SC_MODE_BIT = 0;
  localparam int GPIOP_SC_IE_BIT   = 1;
  localparam int GPIOP_SC_ACK_BIT  = 2;
  localparam int GPIOP_SC_FLAG_BIT = 3;
  localparam int GPIOP_PWR_ACK_BIT = 2;
  localparam int GPIOP_PWR_FLG_BIT = 3;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] GPIOP_RST_DATA  = 8'h00;
  localparam logic [7:0] GPIOP_RST_DIR   = 8'h00;
  localparam logic [7:0] GPIOP_RST_PULL  = 8'h00;
  localparam logic [7:0] GPIOP_RST_SLEW  = 8'hff;
  localparam logic [7:0] GPIOP_RST_DRIVE = 8'h00;
  localparam logic [7:0] GPIOP_RST_ZERO  = 8'h00;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out_en;
    logic [7:0] in_en;
    logic [7:0] pull_en;
    logic [7:0] pull_down;
    logic [7:0] slew_limit;
    logic [7:0] high_drive;
  } gpiop_pad_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpiop_bus_type;

endpackage

// *** gpiop_port.sv ***
// Function
// - direction bit enables output buffer and picks data read source.
// - input buffer on unless analog or output-only pin.
// - peripheral controls output buffer; direction still picks read source.
// - analog disables both buffers; input with buffer off reads 0.
// - analog wins over alternate digital function.
// - pull enable active unless pin is output or analog.
// - slew bit limits edge rate, no effect on inputs.
// - drive bit selects high drive strength.
// - port pins serve as interrupt and wake sources.
// - per-pin select includes pin in interrupt detection.
// - mode bit picks edge or edge-level; polarity per pin.
// - falling edge is sample 1 then 0 on bus clock.
// - rising edge is sample 0 then 1 on bus clock.
// - pin must be seen deasserted before an edge counts.
// - edge mode sets flag; enable raises interrupt request.
// - edge-level mode sets flag on edge or asserted level.
// - writing ack 1 clears flag in edge mode.
// - edge-level ack clears only if all enabled inputs deasserted.
// - pull polarity 0 selects pull-up, 1 pull-down; here pull-down needs irq polarity 1 and pin select set, else pull-up.
// - stop states keep all port latches; here stop_mode blocks config writes only, acks still clear flags.
// - reset: inputs, peripherals off, slew on, low drive, no pulls.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module gpiop_port
  import gpiop_pkg::*;
#(
  parameter int          WIDTH       = 8,
  parameter logic [7:0]  OUTPUT_ONLY = 8'h00,
  parameter logic [7:0]  INPUT_ONLY  = 8'h00
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // shared functions
  input  wire logic [WIDTH-1:0] periph_en,
  input  wire logic [WIDTH-1:0] periph_oe,
  input  wire logic [WIDTH-1:0] periph_out,
  input  wire logic [WIDTH-1:0] analog_en,
  output logic      [WIDTH-1:0] periph_in,
  // power management
  input  wire logic             stop_mode,
  input  wire logic             powerdown_wake,
  output logic                  wake_req,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output gpiop_pad_type         pad_ctl,
  // interrupt request
  output logic                  irq_req
);

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] pin_direction_bit_q;
  logic [WIDTH-1:0] port_pull_enable_q;
  logic [WIDTH-1:0] pin_slew_limit_bit_q;
  logic [WIDTH-1:0] pin_high_drive_bit_q;
  logic [WIDTH-1:0] port_irq_pin_select_q;
  logic [WIDTH-1:0] port_irq_polarity_q;
  logic             port_irq_detect_mode_q;
  logic             port_irq_enable_q;
  logic             port_irq_flag_q;
  logic             powerdown_recovery_flag_q;
  logic [7:0]       rdata_q;

  logic             wr_data;
  logic             wr_sc;
  logic             ack_wr;
  logic [WIDTH-1:0] level_sync;
  logic [WIDTH-1:0] asserted;
  logic [WIDTH-1:0] edge_hit;
  logic [WIDTH-1:0] analog_own;
  logic [WIDTH-1:0] digital_own;
  logic [WIDTH-1:0] in_buf_en;
  logic [WIDTH-1:0] drv_en;
  logic [WIDTH-1:0] read_pin;
  logic             irq_event;
  logic             level_busy;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  assign wr_data = reg_wr && hit(reg_addr, GPIOP_OFF_DATA);
  assign wr_sc   = reg_wr && hit(reg_addr, GPIOP_OFF_IRQ_SC);
  assign ack_wr  = wr_sc && reg_wdata[GPIOP_SC_ACK_BIT];

  // ---------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------
  // reset defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q                 <= GPIOP_RST_DATA[WIDTH-1:0];
      pin_direction_bit_q    <= GPIOP_RST_DIR[WIDTH-1:0];
      port_pull_enable_q     <= GPIOP_RST_PULL[WIDTH-1:0];
      pin_slew_limit_bit_q   <= GPIOP_RST_SLEW[WIDTH-1:0];
      pin_high_drive_bit_q   <= GPIOP_RST_DRIVE[WIDTH-1:0];
      port_irq_pin_select_q  <= GPIOP_RST_ZERO[WIDTH-1:0];
      port_irq_polarity_q    <= GPIOP_RST_ZERO[WIDTH-1:0];
      port_irq_detect_mode_q <= 1'b0;
      port_irq_enable_q      <= 1'b0;
    end else if (reg_wr && !stop_mode) begin
      unique case (reg_addr)
        GPIOP_OFF_DATA:    data_q                <= reg_wdata[WIDTH-1:0];
        GPIOP_OFF_DIR:     pin_direction_bit_q   <= reg_wdata[WIDTH-1:0];
        GPIOP_OFF_PULL:    port_pull_enable_q    <= reg_wdata[WIDTH-1:0];
        GPIOP_OFF_SLEW:    pin_slew_limit_bit_q  <= reg_wdata[WIDTH-1:0];
        GPIOP_OFF_DRIVE:   pin_high_drive_bit_q  <= reg_wdata[WIDTH-1:0];
        GPIOP_OFF_IRQ_SEL: port_irq_pin_select_q <= reg_wdata[WIDTH-1:0];
        GPIOP_OFF_IRQ_POL: port_irq_polarity_q   <= reg_wdata[WIDTH-1:0];
        GPIOP_OFF_IRQ_SC: begin
          port_irq_detect_mode_q <= reg_wdata[GPIOP_SC_MODE_BIT];
          port_irq_enable_q      <= reg_wdata[GPIOP_SC_IE_BIT];
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // pin ownership and pad control
  // ---------------------------------------------------------------------
  // analog has priority
  assign analog_own  = analog_en;
  assign digital_own = periph_en & ~analog_en;

  assign drv_en = ~analog_own & ~INPUT_ONLY[WIDTH-1:0] &
                  ((digital_own & periph_oe) |
                   (~periph_en & pin_direction_bit_q));

  assign in_buf_en = ~analog_own & ~OUTPUT_ONLY[WIDTH-1:0];

  assign pin_oe  = drv_en;
  assign pin_out = (digital_own & periph_out) | (~periph_en & data_q);
  assign periph_in = level_sync & in_buf_en;

  always_comb begin
    pad_ctl = '0;
    pad_ctl.out_en[WIDTH-1:0] = drv_en;
    pad_ctl.in_en[WIDTH-1:0]  = in_buf_en;
    // pull forced off on output or analog
    pad_ctl.pull_en[WIDTH-1:0] = port_pull_enable_q & ~drv_en & ~analog_own;
    pad_ctl.pull_down[WIDTH-1:0] = port_irq_polarity_q &
                                   port_irq_pin_select_q;
    pad_ctl.slew_limit[WIDTH-1:0] = pin_slew_limit_bit_q & drv_en;
    pad_ctl.high_drive[WIDTH-1:0] = pin_high_drive_bit_q;
  end

  // ---------------------------------------------------------------------
  // interrupt detection
  // ---------------------------------------------------------------------
  // per-pin select into detector
  gpiop_edge #(
    .WIDTH (WIDTH)
  ) u_edge (
    .clk        (clk),
    .reset_n    (reset_n),
    .pin_async  (pin_in),
    .sel        (port_irq_pin_select_q & in_buf_en),
    .pol        (port_irq_polarity_q),
    .level_sync (level_sync),
    .asserted   (asserted),
    .edge_hit   (edge_hit)
  );

  assign level_busy = port_irq_detect_mode_q && (|asserted);
  assign irq_event  = (|edge_hit) || level_busy;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_irq_flag_q <= 1'b0;
    end else if (irq_event) begin
      port_irq_flag_q <= 1'b1;
    end else if (ack_wr) begin
      port_irq_flag_q <= 1'b0;
    end
  end

  assign irq_req  = port_irq_flag_q && port_irq_enable_q;
  assign wake_req = irq_req;

  // ---------------------------------------------------------------------
  // powerdown recovery flag
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      powerdown_recovery_flag_q <= 1'b0;
    end else if (powerdown_wake) begin
      powerdown_recovery_flag_q <= 1'b1;
    end else if (reg_wr && hit(reg_addr, GPIOP_OFF_PWR) &&
                 reg_wdata[GPIOP_PWR_ACK_BIT]) begin
      powerdown_recovery_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------
  // read source select
  assign read_pin = level_sync & in_buf_en;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          GPIOP_OFF_DATA: rdata_q[WIDTH-1:0] <=
            (pin_direction_bit_q & data_q) |
            (~pin_direction_bit_q & read_pin);
          GPIOP_OFF_DIR:     rdata_q[WIDTH-1:0] <= pin_direction_bit_q;
          GPIOP_OFF_PULL:    rdata_q[WIDTH-1:0] <= port_pull_enable_q;
          GPIOP_OFF_SLEW:    rdata_q[WIDTH-1:0] <= pin_slew_limit_bit_q;
          GPIOP_OFF_DRIVE:   rdata_q[WIDTH-1:0] <= pin_high_drive_bit_q;
          GPIOP_OFF_IRQ_SEL: rdata_q[WIDTH-1:0] <= port_irq_pin_select_q;
          GPIOP_OFF_IRQ_POL: rdata_q[WIDTH-1:0] <= port_irq_polarity_q;
          GPIOP_OFF_IRQ_SC: begin
            rdata_q[GPIOP_SC_MODE_BIT] <= port_irq_detect_mode_q;
            rdata_q[GPIOP_SC_IE_BIT]   <= port_irq_enable_q;
            rdata_q[GPIOP_SC_FLAG_BIT] <= port_irq_flag_q;
          end
          GPIOP_OFF_PWR:
            rdata_q[GPIOP_PWR_FLG_BIT] <= powerdown_recovery_flag_q;
          default: ;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_analog_no_drive: assert property (
    (analog_en != '0) |-> ((pin_oe & analog_en) == '0))
    else $error("analog pin drives");

  a_pull_off_out: assert property (
    (pad_ctl.pull_en[WIDTH-1:0] & pin_oe) == '0)
    else $error("pull on driven pin");

  a_dir_drives: assert property (
    ((pin_direction_bit_q & ~periph_en & ~analog_en &
      ~INPUT_ONLY[WIDTH-1:0]) & ~pin_oe) == '0)
    else $error("direction bit not driving");

  a_edge_sets_flag: assert property (
    (|edge_hit) |=> port_irq_flag_q)
    else $error("edge missed flag");

  a_ack_clears: assert property (
    (ack_wr && !irq_event && port_irq_flag_q) |=> !port_irq_flag_q)
    else $error("ack did not clear");

  a_level_holds: assert property (
    (port_irq_detect_mode_q && (|asserted) && ack_wr) |=> port_irq_flag_q)
    else $error("level flag cleared");

  a_irq_gate: assert property (
    ((|edge_hit) && port_irq_enable_q && !wr_sc) |=> irq_req)
    else $error("edge did not raise irq");

  a_read_latch: assert property (
    (reg_rd && hit(reg_addr, GPIOP_OFF_DATA)) |=>
      ((rdata_q[WIDTH-1:0] & $past(pin_direction_bit_q)) ==
       ($past(data_q) & $past(pin_direction_bit_q))))
    else $error("data read source wrong");

  a_flag_sticky: assert property (
    (port_irq_flag_q && !ack_wr) |=> port_irq_flag_q)
    else $error("flag dropped alone");

  c_edge_irq:  cover property (|edge_hit ##1 irq_req);
  c_ack_clear: cover property (port_irq_flag_q ##1 ack_wr ##1
                               !port_irq_flag_q);
  c_level_hold: cover property (level_busy && ack_wr);
  c_pwr_flag:  cover property (powerdown_wake ##1
                               powerdown_recovery_flag_q);

endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb
  import gpiop_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic          clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic          stop_mode = 0, powerdown_wake = 0, wake_req, irq_req;
  logic [3:0]    reg_addr = 4'h0;
  logic [7:0]    reg_wdata = 8'h00, periph_en = 8'h00, periph_oe = 8'h00;
  logic [7:0]    periph_out = 8'h00, analog_en = 8'h00, ext_val = 8'h00;
  logic [7:0]    ext_drv = 8'h00, reg_rdata, pin_in, pin_out, pin_oe;
  logic [7:0]    periph_in, dv, rv, pv, sv, hv, ov, lv, xv;
  gpiop_pad_type pad_ctl;
  int            errors = 0, samples_checked = 0, seed = 32'h95bdb9f5;
  logic [3:0]    ra [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hf};
  logic [7:0]    re [7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

  initial forever #2.5 clk = ~clk;

  gpiop_port dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .periph_en, .periph_oe, .periph_out, .analog_en, .periph_in,
    .stop_mode, .powerdown_wake, .wake_req, .pin_in, .pin_out, .pin_oe,
    .pad_ctl, .irq_req);

  gpiop_pins_model pins (.clk, .pin_out, .pin_oe, .pad_ctl, .ext_val,
    .ext_drv, .pin_in);

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic close_out;
    $display("errors=%0d checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic irq_is(logic e);
    int i;
    i = 0;
    while (irq_req !== e && i < 8) begin
      cyc(1);
      i++;
    end
    chk("irq_req", {7'h00, e}, {7'h00, irq_req});
    chk("wake_req", {7'h00, e}, {7'h00, wake_req});
    if (irq_req !== e) close_out;
  endtask

  function automatic logic [7:0] oe_f(logic [7:0] dr);
    return ~analog_en & ((periph_en & periph_oe) | (~periph_en & dr));
  endfunction

  function automatic logic [7:0] drv_f(logic [7:0] dt);
    return (periph_en & periph_out) | (~periph_en & dt);
  endfunction

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    chk("oe_rst", 8'h00, pin_oe);
    chk("slew_rst", 8'h00, pad_ctl.slew_limit);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], xv);
      chk("reg_rst", re[i], xv);
    end
    ext_drv <= 8'hff;
    repeat (16) begin
      dv = 8'($random(seed));
      rv = 8'($random(seed));
      pv = 8'($random(seed));
      sv = 8'($random(seed));
      hv = 8'($random(seed));
      wr(GPIOP_OFF_DATA, dv);
      wr(GPIOP_OFF_DIR, rv);
      wr(GPIOP_OFF_PULL, pv);
      wr(GPIOP_OFF_SLEW, sv);
      wr(GPIOP_OFF_DRIVE, hv);
      @(posedge clk);
      periph_en  <= 8'($random(seed));
      periph_oe  <= 8'($random(seed));
      periph_out <= 8'($random(seed));
      analog_en  <= 8'($random(seed) & $random(seed));
      ext_val    <= 8'($random(seed));
      cyc(4);
      ov = oe_f(rv);
      lv = (ov & drv_f(dv)) | (~ov & ext_val);
      chk("pin_oe", ov, pin_oe);
      chk("out_en", ov, pad_ctl.out_en);
      chk("pin_out", ov & drv_f(dv), ov & pin_out);
      chk("in_en", ~analog_en, pad_ctl.in_en);
      chk("pull_en", pv & ~ov & ~analog_en, pad_ctl.pull_en);
      chk("slew", sv & ov, pad_ctl.slew_limit);
      chk("drive", hv & ov, pad_ctl.high_drive & ov);
      chk("periph_in", lv & ~analog_en, periph_in);
      rd(GPIOP_OFF_DATA, xv);
      chk("data", (rv & dv) | (~rv & ~analog_en & lv), xv);
    end
    @(posedge clk);
    periph_en <= 8'h00;
    analog_en <= 8'h00;
    wr(GPIOP_OFF_DIR, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(GPIOP_OFF_IRQ_SC, 8'h00);
      wr(GPIOP_OFF_IRQ_POL, {7'h00, p[0]});
      wr(GPIOP_OFF_PULL, 8'h01);
      ext_val[0] <= ~p[0];
      wr(GPIOP_OFF_IRQ_SEL, 8'h01);
      wr(GPIOP_OFF_IRQ_SC, 8'h04);
      wr(GPIOP_OFF_IRQ_SC, 8'h02);
      cyc(8);
      chk("pull_dn", {7'h00, p[0]}, pad_ctl.pull_down);
      irq_is(1'b0);
      ext_val[7:1] <= ~ext_val[7:1];
      cyc(8);
      irq_is(1'b0);
      ext_val[0] <= p[0];
      irq_is(1'b1);
      rd(GPIOP_OFF_IRQ_SC, xv);
      chk("sc_flag", 8'h0a, xv);
      wr(GPIOP_OFF_IRQ_SC, 8'h06);
      irq_is(1'b0);
    end
    wr(GPIOP_OFF_IRQ_SEL, 8'h00);
    wr(GPIOP_OFF_IRQ_SEL, 8'h01);
    wr(GPIOP_OFF_IRQ_SC, 8'h06);
    cyc(8);
    irq_is(1'b0);
    wr(GPIOP_OFF_IRQ_SC, 8'h01);
    cyc(4);
    rd(GPIOP_OFF_IRQ_SC, xv);
    chk("lvl_flag", 8'h09, xv);
    irq_is(1'b0);
    wr(GPIOP_OFF_IRQ_SC, 8'h03);
    irq_is(1'b1);
    wr(GPIOP_OFF_IRQ_SC, 8'h07);
    cyc(3);
    irq_is(1'b1);
    ext_val[0] <= 1'b0;
    cyc(4);
    wr(GPIOP_OFF_IRQ_SC, 8'h07);
    irq_is(1'b0);
    @(posedge clk);
    stop_mode <= 1'b1;
    wr(GPIOP_OFF_DIR, 8'hff);
    stop_mode <= 1'b0;
    rd(GPIOP_OFF_DIR, xv);
    chk("stop_dir", 8'h00, xv);
    @(posedge clk);
    powerdown_wake <= 1'b1;
    @(posedge clk);
    powerdown_wake <= 1'b0;
    rd(GPIOP_OFF_PWR, xv);
    chk("pwr_flag", 8'h08, xv);
    wr(GPIOP_OFF_PWR, 8'h04);
    rd(GPIOP_OFF_PWR, xv);
    chk("pwr_ack", 8'h00, xv);
    close_out;
  end
endmodule
